// ### core/dvs_pkg.sv
`default_nettype none
package dvs_pkg;
  // register offsets on the control port
  localparam logic [7:0] DVS_OFS_PWR = 8'h0b;
  localparam logic [7:0] DVS_OFS_VOL_L = 8'h32;
  localparam logic [7:0] DVS_OFS_VOL_R = 8'h33;
  localparam logic [7:0] DVS_OFS_MUTE = 8'h3a;
  localparam logic [7:0] DVS_OFS_RAMP = 8'h3b;
  // field positions
  localparam int DVS_BIT_PWR_ENA_L = 4;
  localparam int DVS_BIT_PWR_ENA_R = 5;
  localparam int DVS_BIT_VOL_ENA = 15;
  localparam int DVS_BIT_COMMIT = 8;
  localparam int DVS_BIT_MUTE = 14;
  localparam int DVS_BIT_RAMPED = 14;
  localparam int DVS_BIT_SPEED = 13;
  // reset values
  localparam logic [7:0] DVS_VOL_RST = 8'hc0;
  localparam logic DVS_MUTE_RST = 1'b1;
  localparam logic [7:0] DVS_VOL_MUTE = 8'h00;
  // ramp divisors, in sample ticks minus one
  localparam logic [4:0] DVS_RAMP_FAST_LAST = 5'h01;
  localparam logic [4:0] DVS_RAMP_SLOW_LAST = 5'h1f;
  // gain arithmetic: mantissas are q15 powers of 2^(k/16)
  localparam logic [4:0] DVS_Q_SHIFT = 5'h0f;
  localparam logic [4:0] DVS_VOL_SH_BASE = 5'h1b;
  localparam logic [15:0] DVS_VOL_MANT [16] = '{
    16'h8000, 16'h85ab, 16'h8b96, 16'h91c4, 16'h9838, 16'h9ef5,
    16'ha5ff, 16'had58, 16'hb505, 16'hbd09, 16'hc567, 16'hce25,
    16'hd745, 16'he0cd, 16'heac1, 16'hf525};
  localparam logic [15:0] DVS_SIDE_ODD_MANT = 16'h5a82;
  localparam logic [3:0] DVS_SIDE_UNITY = 4'hc;
  localparam logic signed [15:0] DVS_SAT_MAX = 16'sh7fff;
  localparam logic signed [15:0] DVS_SAT_MIN = -16'sh7fff - 16'sh0001;
  // sidetone source codes
  localparam logic [1:0] DVS_SRC_ADCL = 2'h1;
  localparam logic [1:0] DVS_SRC_ADCR = 2'h2;
endpackage
`default_nettype wire

// ### core/dvs_fifo.sv
`default_nettype none
module dvs_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // whole fifo state in one record
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
  } dvs_fifo_st_t;
  dvs_fifo_st_t s_q, s_d;
  logic push, pop;

  // honest flags straight from the count
  assign in_ready = (s_q.count != (AW+1)'(DEPTH));
  assign out_valid = (s_q.count != '0);
  assign out_data = s_q.mem[s_q.rptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer and count update
  always_comb
  begin
    s_d = s_q;
    if (push)
    begin
      s_d.mem[s_q.wptr] = in_data;
      s_d.wptr = AW'((s_q.wptr + 1'b1) % DEPTH);
    end
    if (pop)
      s_d.rptr = AW'((s_q.rptr + 1'b1) % DEPTH);
    s_d.count = s_q.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      s_q <= '0;
    else
      s_q <= s_d;
  end
endmodule
`default_nettype wire

// ### core/dvs_top.sv
// Behaviour
// - sidetone gain -36 dB, 3 dB steps, 11xx 0 dB
// - channel enables aliased at two register locations
// - volumes apply together on commit bit write
// - volume code zero mutes, 0.375 dB steps
// - volume codes reset to unity gain
// - soft mute ramps gain down gradually
// - soft mute resets set; host must clear
// - instant unmute jumps to programmed volume
// - ramped unmute climbs to programmed volume
// - ramp rate fs/2 fast or fs/32 slow
// - muting also possible through volume codes
// - timing follows sample rate tick, 8-48 kHz
// - sidetone source none, left adc, right adc
// - sidetone only at equal adc/dac rates
`default_nettype none
module dvs_top
  import dvs_pkg::*;
#(
  parameter int SMP_W = 16,
  parameter int FIFO_DEPTH = 32
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // control register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // playback samples from the audio interface
  input wire logic smp_valid,
  output logic smp_ready,
  input wire logic [SMP_W-1:0] smp_left,
  input wire logic [SMP_W-1:0] smp_right,
  // sample rate strobe, one pulse per fs period
  input wire logic sample_tick,
  // sidetone inputs from the adc filters
  input wire logic [SMP_W-1:0] adc_left,
  input wire logic [SMP_W-1:0] adc_right,
  input wire logic same_rate,
  input wire logic [3:0] left_sidetone_gain,
  input wire logic [3:0] right_sidetone_gain,
  input wire logic [1:0] left_sidetone_source,
  input wire logic [1:0] right_sidetone_source,
  // scaled samples towards the dac
  output logic out_valid,
  output logic [SMP_W-1:0] out_left,
  output logic [SMP_W-1:0] out_right
);
  // all state of the block in one record; index 0 left, 1 right
  typedef struct packed {
    logic [1:0] ena;
    logic [1:0][7:0] pend;
    logic [1:0][7:0] vol;
    logic [1:0][7:0] app;
    logic mute;
    logic ramped;
    logic speed;
    logic [4:0] rcnt;
    logic [15:0] rdata;
    logic ovalid;
    logic [1:0][SMP_W-1:0] osmp;
  } dvs_state_t;
  dvs_state_t s_q, s_d;

  // fifo drain side
  logic f_valid;
  logic [2*SMP_W-1:0] f_data;
  logic pop;
  // ramp step strobe
  logic ramp_tick;
  logic [4:0] rlast;
  // decoded writes
  logic wr_vol, commit;
  // per-channel mixed result
  logic [1:0][SMP_W-1:0] mix;

  // 32-word buffer so the interface can run ahead of the fs strobe
  dvs_fifo #(
    .WIDTH(2*SMP_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .in_valid(smp_valid),
    .in_ready(smp_ready),
    .in_data({smp_left, smp_right}),
    .out_valid(f_valid),
    .out_ready(sample_tick),
    .out_data(f_data)
  );
  // drained only on the fs strobe, so a slow dac back-pressures the source
  assign pop = sample_tick && f_valid;

  // ramp divider counts sample ticks, so timing scales with fs
  assign rlast = s_q.speed ? DVS_RAMP_SLOW_LAST : DVS_RAMP_FAST_LAST;
  assign ramp_tick = sample_tick && ((s_q.rcnt & rlast) == rlast);

  // volume write with commit bit set on either channel
  assign wr_vol = reg_wr_en &&
    (reg_addr == DVS_OFS_VOL_L || reg_addr == DVS_OFS_VOL_R);
  assign commit = wr_vol && reg_wdata[DVS_BIT_COMMIT];

  // saturate a wide product or sum into a sample
  function automatic logic signed [15:0] dvs_sat(
    input logic signed [32:0] v
  );
    begin
      if (v > 33'(DVS_SAT_MAX))
        dvs_sat = DVS_SAT_MAX;
      else if (v < 33'(DVS_SAT_MIN))
        dvs_sat = DVS_SAT_MIN;
      else
        dvs_sat = 16'(v);
    end
  endfunction

  // multiply by a q15-style mantissa, then shift down
  function automatic logic signed [15:0] dvs_scale(
    input logic signed [15:0] x,
    input logic [15:0] m,
    input logic [4:0] sh
  );
    logic signed [32:0] p;
    begin
      p = 33'(x) * 33'($signed({1'b0, m}));
      dvs_scale = dvs_sat(p >>> sh);
    end
  endfunction

  // per-channel gain and sidetone mix
  for (genvar c = 0; c < 2; c++)
  begin : g_ch
    logic signed [15:0] smp, adc, pv, sv;
    logic [7:0] code;
    logic [3:0] sg, nd;
    logic [1:0] src;
    logic side_on;
    // left channel sits in the upper half of the fifo word
    assign smp = (c == 0) ? f_data[2*SMP_W-1:SMP_W] : f_data[SMP_W-1:0];
    assign code = s_q.app[c];
    assign sg = (c == 0) ? left_sidetone_gain : right_sidetone_gain;
    assign src = (c == 0) ? left_sidetone_source : right_sidetone_source;
    // playback gain: 16 codes per octave, code c0 is unity
    always_comb
    begin
      if (code == DVS_VOL_MUTE)
        pv = '0;
      else
        pv = dvs_scale(smp, DVS_VOL_MANT[code[3:0]],
          5'(DVS_VOL_SH_BASE - {1'b0, code[7:4]}));
    end
    // sidetone gain: every two codes halve, odd codes add root half
    assign nd = (sg >= DVS_SIDE_UNITY) ? 4'h0 : 4'(DVS_SIDE_UNITY - sg);
    // unused source code 11 mixes nothing
    assign side_on = same_rate &&
      (src == DVS_SRC_ADCL || src == DVS_SRC_ADCR);
    assign adc = (src == DVS_SRC_ADCR) ? adc_right : adc_left;
    always_comb
    begin
      if (!side_on)
        sv = '0;
      else
        sv = dvs_scale(adc, nd[0] ? DVS_SIDE_ODD_MANT : DVS_VOL_MANT[0],
          5'(DVS_Q_SHIFT + {2'b00, nd[3:1]}));
    end
    // sum can exceed full scale, so clip rather than wrap
    assign mix[c] = dvs_sat(33'(pv) + 33'(sv));
  end

  // next-state logic for registers, ramp and output stage
  always_comb
  begin
    s_d = s_q;
    s_d.ovalid = 1'b0;
    // ramp divider advances on every sample tick
    if (sample_tick)
      s_d.rcnt = s_q.rcnt + 5'h01;
    // register writes; unmapped offsets are ignored
    if (reg_wr_en)
    begin
      case (reg_addr)
        DVS_OFS_PWR:
        begin
          // same storage as bit 15 of the volume registers
          s_d.ena[0] = reg_wdata[DVS_BIT_PWR_ENA_L];
          s_d.ena[1] = reg_wdata[DVS_BIT_PWR_ENA_R];
        end
        DVS_OFS_VOL_L:
        begin
          s_d.ena[0] = reg_wdata[DVS_BIT_VOL_ENA];
          s_d.pend[0] = reg_wdata[7:0];
        end
        DVS_OFS_VOL_R:
        begin
          s_d.ena[1] = reg_wdata[DVS_BIT_VOL_ENA];
          s_d.pend[1] = reg_wdata[7:0];
        end
        DVS_OFS_MUTE:
          s_d.mute = reg_wdata[DVS_BIT_MUTE];
        DVS_OFS_RAMP:
        begin
          s_d.ramped = reg_wdata[DVS_BIT_RAMPED];
          s_d.speed = reg_wdata[DVS_BIT_SPEED];
        end
        default:
          s_d.mute = s_q.mute;
      endcase
    end
    // both channels take their pending codes in the same cycle,
    // including the code carried by the committing write itself
    if (commit)
      s_d.vol = s_d.pend;
    // applied gain code per channel
    for (int c = 0; c < 2; c++)
    begin
      if (s_q.mute)
      begin
        // fade down one code per ramp tick, never a single cut
        if (ramp_tick && s_q.app[c] != DVS_VOL_MUTE)
          s_d.app[c] = s_q.app[c] - 8'h01;
      end
      else if (s_q.ramped && s_q.app[c] < s_q.vol[c])
      begin
        // climb one code per ramp tick to the programmed level
        if (ramp_tick)
          s_d.app[c] = s_q.app[c] + 8'h01;
      end
      else
        s_d.app[c] = s_q.vol[c];
    end
    // read data registered; reserved bits read zero
    if (reg_rd_en)
    begin
      s_d.rdata = '0;
      case (reg_addr)
        DVS_OFS_PWR:
        begin
          s_d.rdata[DVS_BIT_PWR_ENA_L] = s_q.ena[0];
          s_d.rdata[DVS_BIT_PWR_ENA_R] = s_q.ena[1];
        end
        DVS_OFS_VOL_L:
        begin
          s_d.rdata[DVS_BIT_VOL_ENA] = s_q.ena[0];
          s_d.rdata[7:0] = s_q.pend[0];
        end
        DVS_OFS_VOL_R:
        begin
          s_d.rdata[DVS_BIT_VOL_ENA] = s_q.ena[1];
          s_d.rdata[7:0] = s_q.pend[1];
        end
        DVS_OFS_MUTE:
          s_d.rdata[DVS_BIT_MUTE] = s_q.mute;
        DVS_OFS_RAMP:
        begin
          s_d.rdata[DVS_BIT_RAMPED] = s_q.ramped;
          s_d.rdata[DVS_BIT_SPEED] = s_q.speed;
        end
        default:
          s_d.rdata = '0;
      endcase
    end
    // one output pair per fs tick; disabled channels emit silence
    if (pop)
    begin
      s_d.ovalid = 1'b1;
      for (int c = 0; c < 2; c++)
        s_d.osmp[c] = s_q.ena[c] ? mix[c] : '0;
    end
  end

  // state register; muted and at unity code out of reset
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_q <= '0;
      s_q.pend <= {DVS_VOL_RST, DVS_VOL_RST};
      s_q.vol <= {DVS_VOL_RST, DVS_VOL_RST};
      s_q.mute <= DVS_MUTE_RST;
    end
    else
      s_q <= s_d;
  end

  // outputs straight from flip-flops
  assign reg_rdata = s_q.rdata;
  assign out_valid = s_q.ovalid;
  assign out_left = s_q.osmp[0];
  assign out_right = s_q.osmp[1];

  // checks on the block's own behaviour
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  sequence seq_mute_step;
    s_q.mute && ramp_tick && s_q.app[0] != DVS_VOL_MUTE;
  endsequence
  sequence seq_up_step;
    !s_q.mute && s_q.ramped && ramp_tick && s_q.app[0] < s_q.vol[0];
  endsequence

  a_mute_ramp_down: assert property (
    seq_mute_step |=> s_q.app[0] == $past(s_q.app[0]) - 8'h01)
    else $error("soft mute did not step gain down by one");
  a_ramp_up_step: assert property (
    seq_up_step |=> s_q.app[0] == $past(s_q.app[0]) + 8'h01)
    else $error("ramped unmute did not step gain up by one");
  a_instant_unmute: assert property (
    !s_q.mute && !s_q.ramped |=> s_q.app[1] == $past(s_q.vol[1]))
    else $error("instant unmute did not reach volume");
  a_ramp_hold: assert property (
    s_q.mute && !ramp_tick |=> $stable(s_q.app))
    else $error("gain moved without a ramp tick");
  // every odd sample tick steps the gain at the fast rate
  a_fast_rate: assert property (
    !s_q.speed && sample_tick |-> ramp_tick == s_q.rcnt[0])
    else $error("fast ramp not every second sample");
  // only the last of 32 sample ticks steps the gain at the slow rate
  a_slow_rate: assert property (
    s_q.speed && sample_tick |-> ramp_tick == (&s_q.rcnt))
    else $error("slow ramp not every 32nd sample");
  a_commit_only: assert property (
    !$stable(s_q.vol) |-> $past(commit))
    else $error("volume applied without commit write");
  a_commit_both: assert property (
    commit |=> s_q.vol == $past(s_d.pend))
    else $error("commit did not apply both channels");
  a_alias_enable: assert property (
    reg_wr_en && reg_addr == DVS_OFS_PWR ##1 reg_rd_en &&
      reg_addr == DVS_OFS_VOL_L |=>
      reg_rdata[DVS_BIT_VOL_ENA] == $past(reg_wdata[DVS_BIT_PWR_ENA_L], 2))
    else $error("enable alias read mismatch");
  a_disabled_silent: assert property (
    pop && !s_q.ena[0] |=> out_valid && out_left == '0)
    else $error("disabled channel not silent");
  a_code_zero_mute: assert property (
    pop && s_q.app[1] == DVS_VOL_MUTE && !same_rate |=> out_right == '0)
    else $error("zero volume code not silent");
  a_mute_held: assert property (
    s_q.mute && !(reg_wr_en && reg_addr == DVS_OFS_MUTE) |=> s_q.mute)
    else $error("soft mute cleared without a write");
endmodule
`default_nettype wire

// ### bench/dvs_src.sv
`default_nettype none
// stand-in for the audio interface feeding playback pairs
module dvs_src (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // stream towards the block
  output logic smp_valid,
  input wire logic smp_ready,
  output logic [15:0] smp_left,
  output logic [15:0] smp_right
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle until the first offer
  initial
  begin
    smp_valid = 1'b0;
    smp_left = 16'h0000;
    smp_right = 16'h0000;
  end

  // offer one pair after some idle cycles, hold it until taken or for at most 200 cycles
  task automatic send(input logic [15:0] l, input logic [15:0] r,
    input int stall, output bit ok);
    int n;
    ok = 1'b0;
    repeat (stall) @(posedge core_clk);
    @(posedge core_clk);
    smp_valid <= 1'b1;
    smp_left <= l;
    smp_right <= r;
    for (n = 0; n < 200 && !ok; n++)
    begin
      @(posedge core_clk);
      ok = (smp_ready === 1'b1);
    end
    // released data flips so a stale pair never looks like a fresh one
    smp_valid <= 1'b0;
    smp_left <= ~l;
    smp_right <= ~r;
  endtask
endmodule
`default_nettype wire

// ### bench/tb_top.sv
`default_nettype none
module tb_top
  import dvs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // design inputs and outputs
  logic core_clk, rst_b, reg_wr_en, reg_rd_en, sample_tick, same_rate;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, adc_left, adc_right;
  logic [15:0] smp_left, smp_right, out_left, out_right, mix_w;
  logic smp_valid, smp_ready, out_valid, rd_q;
  logic [3:0] left_sidetone_gain, right_sidetone_gain;
  logic [1:0] left_sidetone_source, right_sidetone_source;
  // expected results waiting for their outputs
  logic [15:0] rq[$];
  logic [31:0] oq[$];
  logic [31:0] exp_w, rng;
  int err_count, cmp_count;
  bit ok;

  dvs_top #(.SMP_W(16), .FIFO_DEPTH(32)) uut (
    .core_clk(core_clk), .rst_b(rst_b), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .smp_valid(smp_valid), .smp_ready(smp_ready),
    .smp_left(smp_left), .smp_right(smp_right),
    .sample_tick(sample_tick), .adc_left(adc_left),
    .adc_right(adc_right), .same_rate(same_rate),
    .left_sidetone_gain(left_sidetone_gain),
    .right_sidetone_gain(right_sidetone_gain),
    .left_sidetone_source(left_sidetone_source),
    .right_sidetone_source(right_sidetone_source),
    .out_valid(out_valid), .out_left(out_left), .out_right(out_right));

  dvs_src src (.core_clk(core_clk), .rst_b(rst_b), .smp_valid(smp_valid),
    .smp_ready(smp_ready), .smp_left(smp_left), .smp_right(smp_right));

  // 125 MHz core clock
  always #4 core_clk = ~core_clk;

  // xorshift source for sample values and stalls
  function automatic logic [15:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[15:0];
  endfunction

  task automatic cmp(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    if (err_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // a bounded wait that ran out ends the run
  task automatic need(input bit k);
    if (!k)
    begin
      err_count++;
      final_report();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    rq.push_back(e);
    @(posedge core_clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd_en <= 1'b0;
  endtask

  // write, then read in the very next cycle to catch the alias at once
  task automatic wr_rd(input logic [7:0] a, input logic [15:0] d,
    input logic [7:0] b, input logic [15:0] e);
    rq.push_back(e);
    @(posedge core_clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
    reg_rd_en <= 1'b1;
    reg_addr <= b;
    @(posedge core_clk);
    reg_rd_en <= 1'b0;
  endtask

  // one-cycle fs strobes, spaced so the fifo always sees them apart
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      sample_tick <= 1'b1;
      @(posedge core_clk);
      sample_tick <= 1'b0;
      repeat (2) @(posedge core_clk);
    end
  endtask

  // push one pair, note the scaled result, then release it with a tick
  task automatic play(input logic [15:0] x, input logic [15:0] el,
    input logic [15:0] er);
    oq.push_back({el, er});
    src.send(x, x, int'(rnd() % 16'h0004), ok);
    need(ok);
    tick(1);
  endtask

  // watcher: reads answer one cycle late, samples on out_valid
  always @(posedge core_clk)
  begin
    if (rd_q === 1'b1)
      cmp("reg_rdata", rq.pop_front(), reg_rdata);
    if (out_valid === 1'b1)
    begin
      if (oq.size() == 0)
        cmp("out_valid", 16'h0000, 16'h0001);
      else
      begin
        exp_w = oq.pop_front();
        cmp("out_left", exp_w[31:16], out_left);
        cmp("out_right", exp_w[15:0], out_right);
      end
    end
    rd_q <= reg_rd_en;
  end

  initial
  begin
    core_clk = 1'b0;
    rst_b = 1'b0;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    sample_tick = 1'b0;
    same_rate = 1'b0;
    adc_left = 16'h0000;
    adc_right = 16'h0000;
    left_sidetone_gain = 4'h0;
    right_sidetone_gain = 4'h0;
    left_sidetone_source = 2'h0;
    right_sidetone_source = 2'h0;
    rd_q = 1'b0;
    rng = 32'h0000_003e;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    // reset values, unmapped read
    rd(DVS_OFS_PWR, 16'h0000);
    rd(DVS_OFS_VOL_L, 16'h00c0);
    rd(DVS_OFS_VOL_R, 16'h00c0);
    rd(DVS_OFS_MUTE, 16'h4000);
    rd(DVS_OFS_RAMP, 16'h0000);
    rd(8'h40, 16'h0000);
    // enable bits shared between two locations
    wr_rd(DVS_OFS_PWR, 16'h0030, DVS_OFS_VOL_L, 16'h80c0);
    rd(DVS_OFS_VOL_R, 16'h80c0);
    wr(DVS_OFS_VOL_L, 16'h00c0);
    rd(DVS_OFS_PWR, 16'h0020);
    wr(DVS_OFS_VOL_L, 16'h80c0);
    play(16'h1234, 16'h0000, 16'h0000);
    wr(DVS_OFS_MUTE, 16'h0000);
    play(16'h1234, 16'h1234, 16'h1234);
    // pending volume waits for the commit bit
    wr(DVS_OFS_VOL_L, 16'h80b0);
    play(16'h2000, 16'h2000, 16'h2000);
    wr(DVS_OFS_VOL_R, 16'h81b0);
    play(16'h2000, 16'h1000, 16'h1000);
    wr(DVS_OFS_VOL_L, 16'h8100);
    play(16'h2000, 16'h0000, 16'h1000);
    wr(DVS_OFS_VOL_L, 16'h81c0);
    wr(DVS_OFS_VOL_R, 16'h81c0);
    wr(DVS_OFS_PWR, 16'h0010);
    play(16'h2000, 16'h2000, 16'h0000);
    wr(DVS_OFS_PWR, 16'h0020);
    play(16'h2000, 16'h0000, 16'h2000);
    wr(DVS_OFS_PWR, 16'h0030);
    // 16 volume steps take 32 ticks fast, 512 slow
    for (int s = 0; s < 2; s++)
    begin
      wr(DVS_OFS_RAMP, (s != 0) ? 16'h2000 : 16'h0000);
      wr(DVS_OFS_MUTE, 16'h4000);
      tick((s != 0) ? 512 : 32);
      play(16'h2000, 16'h1000, 16'h1000);
      wr(DVS_OFS_MUTE, 16'h0000);
      play(16'h2000, 16'h2000, 16'h2000);
    end
    // full mute, then ramped unmute as for a pause mid-track
    wr(DVS_OFS_RAMP, 16'h4000);
    wr(DVS_OFS_MUTE, 16'h4000);
    tick(400);
    play(16'h4000, 16'h0000, 16'h0000);
    wr(DVS_OFS_MUTE, 16'h0000);
    tick(64);
    play(16'h4000, 16'h0010, 16'h0010);
    tick(400);
    play(16'h4000, 16'h4000, 16'h4000);
    wr(DVS_OFS_RAMP, 16'h0000);
    // sidetone: every unity gain code with every source code
    adc_left <= 16'h0100;
    adc_right <= 16'h0200;
    same_rate <= 1'b1;
    for (int g = 12; g < 16; g++)
    begin
      for (int c = 0; c < 4; c++)
      begin
        left_sidetone_gain <= 4'(g);
        right_sidetone_gain <= 4'(g);
        left_sidetone_source <= 2'(c);
        right_sidetone_source <= 2'(c);
        mix_w = (c == 1) ? 16'h1100 : (c == 2) ? 16'h1200 : 16'h1000;
        play(16'h1000, mix_w, mix_w);
      end
    end
    // attenuated codes: -36 dB is 1/64, -6 dB half, -3 dB root half
    adc_left <= 16'h4000;
    left_sidetone_source <= 2'h1;
    right_sidetone_source <= 2'h1;
    left_sidetone_gain <= 4'h0;
    right_sidetone_gain <= 4'h0;
    play(16'h0000, 16'h0100, 16'h0100);
    left_sidetone_gain <= 4'ha;
    right_sidetone_gain <= 4'ha;
    play(16'h0000, 16'h2000, 16'h2000);
    left_sidetone_gain <= 4'hb;
    right_sidetone_gain <= 4'hb;
    play(16'h0000, 16'h2d41, 16'h2d41);
    same_rate <= 1'b0;
    left_sidetone_source <= 2'h1;
    right_sidetone_source <= 2'h1;
    play(16'h1000, 16'h1000, 16'h1000);
    left_sidetone_source <= 2'h0;
    right_sidetone_source <= 2'h0;
    // fill the fifo until it refuses, then drain in order
    for (int i = 0; i < 32; i++)
    begin
      mix_w = rnd();
      oq.push_back({mix_w, ~mix_w});
      src.send(mix_w, ~mix_w, int'(rnd() % 16'h0003), ok);
      need(ok);
    end
    @(posedge core_clk);
    cmp("smp_ready", 16'h0000, {15'h0000, smp_ready});
    tick(32);
    cmp("smp_ready", 16'h0001, {15'h0000, smp_ready});
    for (int n = 0; n < 100 && oq.size() != 0; n++)
      @(posedge core_clk);
    need(oq.size() == 0);
    final_report();
  end
endmodule
`default_nettype wire
